/* rtl/vfr_fault_response.sv */
// Output-voltage fault response: settings, masking, alert, status and retry
`timescale 1ns/1ps

// Overview of operation
// - Response code 10 disables output on fault, then applies retry bits 5:3.
// - Any output-voltage fault pulls the alert line low.
// - Fault status bits are sticky; only clear-faults command clears them.
// - Overvoltage retry 000 keeps output off until the device restarts.
// - Undervoltage retry 000 keeps output off until the fault is cleared.
// - Retry 111 restarts endlessly until off command, bias loss or other fault.
// - Overvoltage retrying ends on control pin or operation command off.
// - Undervoltage retrying ends on enable pin or operation command off.
// - Retry delay is fixed at 70 ms; bits 2:0 are ignored.
// - Overvoltage action register resets to 80h.
// - Undervoltage action register resets to 80h.
// - Undervoltage threshold is 16-bit unsigned, LSB 2^-13 volts.
// - Undervoltage detection is masked during ramp, before power good, or disabled.
// - Undervoltage fault only after power good has asserted.
// - Undervoltage threshold defaults to 0.85 times the strapped setpoint.
// - Actions are one byte, threshold two bytes, all write-protectable.
// - Overvoltage threshold uses the same 2^-13 volt unsigned scaling.
module vfr_fault_response #(
  parameter int RETRY_CYCLES = vfr_pkg::RETRY_DELAY_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] setpoint_strap,
  input  wire logic [15:0] ov_threshold,
  input  wire logic [15:0] vout_sample,
  input  wire logic        sample_valid,
  input  wire logic        output_ramping,
  input  wire logic        output_good_flag,
  input  wire logic        control_pin_on,
  input  wire logic        enable_pin_on,
  input  wire logic        operation_on,
  input  wire logic        other_fault_shutdown,
  input  wire logic        write_protect,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        clear_faults,
  output logic [15:0]      cmd_rdata,
  output logic             host_alert_n,
  output logic             ov_fault_status_reg,
  output logic             uv_fault_status_reg,
  output logic             output_enable_reg
);
  import vfr_pkg::*;

  logic             init_reg;
  logic             load_defaults;
  logic [7:0]       ov_action_reg;
  logic [7:0]       uv_action_reg;
  logic [15:0]      uv_threshold_reg;
  logic [31:0]      uv_default_prod;
  logic [15:0]      uv_default;
  vfr_state_t       state_reg;
  logic             last_fault_uv_reg;
  logic             ov_detect;
  logic             uv_detect;
  logic             any_fault;
  logic             fault_retries;
  logic             off_command;
  logic             timer_start;
  logic             timer_done;
  logic             timer_busy;
  logic [1:0]       resp_sel;
  logic [2:0]       retry_sel;

  // Defaults (UV limit from the strap, actions from ACTION_RESET) load after reset release, never inside the async reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end
  assign load_defaults = init_reg;

  vfr_action_reg #(.WIDTH(8)) u_ov_action (
    .clk           (clk),
    .reset_n       (reset_n),
    .load_en       (load_defaults),
    .reset_value   (ACTION_RESET),
    .write_en      (cmd_write && cmd_code == CMD_OV_ACTION),
    .write_protect (write_protect),
    .write_data    (cmd_wdata[7:0]),
    .value_reg     (ov_action_reg)
  );

  vfr_action_reg #(.WIDTH(8)) u_uv_action (
    .clk           (clk),
    .reset_n       (reset_n),
    .load_en       (load_defaults),
    .reset_value   (ACTION_RESET),
    .write_en      (cmd_write && cmd_code == CMD_UV_ACTION),
    .write_protect (write_protect),
    .write_data    (cmd_wdata[7:0]),
    .value_reg     (uv_action_reg)
  );

  // Integer 85/100 scaling truncates toward zero
  assign uv_default_prod = setpoint_strap * UV_SCALE_NUM;
  assign uv_default      = 16'(uv_default_prod / 32'(UV_SCALE_DEN));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_threshold_reg <= '0;
    end else if (load_defaults) begin
      uv_threshold_reg <= uv_default;
    end else if (cmd_write && cmd_code == CMD_UV_THRESHOLD && !write_protect) begin
      uv_threshold_reg <= cmd_wdata;
    end
  end

  // Readback: one byte for actions, two for the threshold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_rdata <= '0;
    end else if (cmd_code == CMD_OV_ACTION) begin
      cmd_rdata <= {8'h00, ov_action_reg};
    end else if (cmd_code == CMD_UV_THRESHOLD) begin
      cmd_rdata <= uv_threshold_reg;
    end else if (cmd_code == CMD_UV_ACTION) begin
      cmd_rdata <= {8'h00, uv_action_reg};
    end else begin
      cmd_rdata <= '0;
    end
  end

  // Both limits compare raw codes at the same 2^-13 V weight
  assign ov_detect = sample_valid && output_enable_reg && (state_reg == VFR_RUN)
                     && (vout_sample > ov_threshold);
  assign uv_detect = sample_valid && output_enable_reg && (state_reg == VFR_RUN)
                     && !output_ramping && output_good_flag
                     && (vout_sample < uv_threshold_reg) && !ov_detect;
  assign any_fault = ov_detect || uv_detect;

  assign resp_sel  = ov_detect ? ov_action_reg[RESP_MSB:RESP_LSB] : uv_action_reg[RESP_MSB:RESP_LSB];
  assign retry_sel = ov_detect ? ov_action_reg[RETRY_MSB:RETRY_LSB] : uv_action_reg[RETRY_MSB:RETRY_LSB];
  // Only 10/111 retries; all other codes shut down with no retry
  assign fault_retries = (resp_sel == RESP_DISABLE_RETRY) && (retry_sel == RETRY_CONTINUOUS);

  // Off from control pin for OV, enable pin for UV, operation command for both
  assign off_command = !operation_on
                       || (!last_fault_uv_reg && !control_pin_on)
                       || (last_fault_uv_reg && !enable_pin_on);

  assign timer_start = any_fault && fault_retries;

  vfr_retry_timer #(.DELAY_CYCLES(RETRY_CYCLES)) u_timer (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (timer_start),
    .abort    ((state_reg == VFR_WAIT_RETRY) && (off_command || other_fault_shutdown)),
    .busy_reg (timer_busy),
    .done     (timer_done)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg         <= VFR_RUN;
      output_enable_reg <= 1'b0;
      last_fault_uv_reg <= 1'b0;
    end else begin
      case (state_reg)
        VFR_RUN: begin
          output_enable_reg <= !init_reg && operation_on && control_pin_on && enable_pin_on;
          if (any_fault) begin
            output_enable_reg <= 1'b0;
            last_fault_uv_reg <= uv_detect;
            state_reg         <= fault_retries ? VFR_WAIT_RETRY : VFR_LATCHED;
          end
        end
        VFR_WAIT_RETRY: begin
          if (off_command || other_fault_shutdown) begin
            state_reg <= VFR_LATCHED;
          end else if (timer_done) begin
            state_reg <= VFR_RUN;
          end
        end
        VFR_LATCHED: begin
          output_enable_reg <= 1'b0;
          // OV latch holds until reset; UV latch releases on clear-faults
          if (last_fault_uv_reg && clear_faults) begin
            state_reg <= VFR_RUN;
          end
        end
        default: state_reg <= VFR_RUN;
      endcase
    end
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ov_fault_status_reg <= 1'b0;
      uv_fault_status_reg <= 1'b0;
    end else begin
      ov_fault_status_reg <= ov_detect || (ov_fault_status_reg && !clear_faults);
      uv_fault_status_reg <= uv_detect || (uv_fault_status_reg && !clear_faults);
    end
  end

  assign host_alert_n = !(ov_fault_status_reg || uv_fault_status_reg);

  sequence s_wait_entered;
    state_reg == VFR_WAIT_RETRY && timer_busy;
  endsequence

  a_fault_disables: assert property (@(posedge clk) disable iff (!reset_n)
    any_fault |=> !output_enable_reg) else $error("Output still on after fault");
  a_alert_follows: assert property (@(posedge clk) disable iff (!reset_n)
    any_fault |=> !host_alert_n) else $error("Alert not asserted after fault");
  a_status_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    ov_fault_status_reg && !clear_faults |=> ov_fault_status_reg) else $error("OV status lost");
  a_ov_latch_holds: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == VFR_LATCHED && !last_fault_uv_reg |=> state_reg == VFR_LATCHED)
    else $error("OV latch released");
  a_uv_latch_clear: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == VFR_LATCHED && last_fault_uv_reg && clear_faults |=> state_reg == VFR_RUN)
    else $error("UV latch not released");
  a_retry_entered: assert property (@(posedge clk) disable iff (!reset_n)
    timer_start |=> s_wait_entered) else $error("Retry wait not entered");
  a_off_ends_retry: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == VFR_WAIT_RETRY && off_command |=> state_reg == VFR_LATCHED)
    else $error("Off command ignored while retrying");
  a_uv_masked: assert property (@(posedge clk) disable iff (!reset_n)
    !output_good_flag || output_ramping |-> !uv_detect) else $error("UV raised while masked");
  a_action_reset: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(init_reg) |-> ov_action_reg == ACTION_RESET && uv_action_reg == ACTION_RESET)
    else $error("Action registers not at reset value");
endmodule

/* pkg/vfr_pkg.sv */
// Constants and types for the output-voltage fault response block
package vfr_pkg;
  localparam logic [7:0]  CMD_OV_ACTION      = 8'h41;
  localparam logic [7:0]  CMD_UV_THRESHOLD   = 8'h44;
  localparam logic [7:0]  CMD_UV_ACTION      = 8'h45;
  localparam logic [7:0]  ACTION_RESET       = 8'h80;
  localparam int          RESP_MSB           = 7;
  localparam int          RESP_LSB           = 6;
  localparam int          RETRY_MSB          = 5;
  localparam int          RETRY_LSB          = 3;
  localparam logic [1:0]  RESP_DISABLE_RETRY = 2'h2;
  localparam logic [2:0]  RETRY_NONE         = 3'h0;
  localparam logic [2:0]  RETRY_CONTINUOUS   = 3'h7;
  localparam int          LIMIT_FRAC_BITS    = 13;
  localparam logic [15:0] UV_SCALE_NUM       = 16'h0055;
  localparam logic [15:0] UV_SCALE_DEN       = 16'h0064;
  localparam int          CLK_PERIOD_PS      = 5000;
  localparam int          RETRY_DELAY_MS     = 70;
  localparam int          RETRY_DELAY_CYCLES = RETRY_DELAY_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int          DELAY_CNT_W        = 24;

  typedef enum logic [1:0] {
    VFR_RUN,
    VFR_LATCHED,
    VFR_WAIT_RETRY
  } vfr_state_t;
endpackage

/* rtl/vfr_action_reg.sv */
// One command register with reset value and write protection
`timescale 1ns/1ps
module vfr_action_reg #(
  parameter int         WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             load_en,
  input  wire logic [WIDTH-1:0] reset_value,
  input  wire logic             write_en,
  input  wire logic             write_protect,
  input  wire logic [WIDTH-1:0] write_data,
  output logic      [WIDTH-1:0] value_reg
);
  // Reset leaves zero; the reset value is loaded on the clocked load_en after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      value_reg <= '0;
    end else if (load_en) begin
      value_reg <= reset_value;
    end else if (write_en && !write_protect) begin
      value_reg <= write_data;
    end
  end
endmodule

/* rtl/vfr_retry_timer.sv */
// Fixed retry delay counter
`timescale 1ns/1ps
module vfr_retry_timer #(
  parameter int DELAY_CYCLES = 14000000
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy_reg,
  output logic      done
);
  import vfr_pkg::*;
  logic [DELAY_CNT_W-1:0] count_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
    end else if (abort) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
    end else if (start) begin
      count_reg <= DELAY_CNT_W'(DELAY_CYCLES - 1);
      busy_reg  <= 1'b1;
    end else if (busy_reg) begin
      if (count_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  assign done = busy_reg && (count_reg == '0) && !abort;
endmodule

/* bench/vfr_host_model.sv */
// Host model issuing command writes, reads and clear-faults pulses
`timescale 1ns/1ps
module vfr_host_model (
  input  wire logic        clk,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  output logic             clear_faults,
  output logic             write_protect,
  input  wire logic [15:0] cmd_rdata
);
  initial begin
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    clear_faults = 1'b0;
    write_protect = 1'b0;
  end
  // Whole word per strobe; data is scrambled once the strobe is gone
  task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd_write <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_write <= 1'b0;
    cmd_wdata <= ~data;
  endtask
  task automatic read_cmd(input logic [7:0] code, output logic [15:0] data);
    @(posedge clk);
    cmd_code <= code;
    repeat (2) @(posedge clk);
    #1;
    data = cmd_rdata;
  endtask
  task automatic clear_all();
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
  endtask
  task automatic protect(input logic on);
    @(posedge clk);
    write_protect <= on;
  endtask
endmodule

/* bench/test_vfr_fault_response.sv */
// Self-checking bench for the output-voltage fault response block
`timescale 1ns/1ps
module test_vfr_fault_response;
  import vfr_pkg::*;
  localparam int          R    = 20;
  localparam logic [15:0] NORM = 16'h2000;
  localparam logic [15:0] HIGH = 16'h3000;
  localparam logic [15:0] LOW  = 16'h1000;
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] vout    = NORM;
  logic        good    = 1'b0;
  logic        ramp    = 1'b0;
  logic        ctl_on  = 1'b1;
  logic        en_on   = 1'b1;
  logic        op_on   = 1'b1;
  logic        other   = 1'b0;
  logic        cmd_write, clear_faults, write_protect;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, rd;
  logic        alert_n, ov_st, uv_st, en;
  int          failures = 0;
  int          total_checks = 0;
  int          n;
  always #2.5 clk = ~clk;
  vfr_fault_response #(.RETRY_CYCLES(R)) dut (.clk(clk), .reset_n(reset_n), .setpoint_strap(16'h2000),
    .ov_threshold(16'h2400), .vout_sample(vout), .sample_valid(1'b1), .output_ramping(ramp),
    .output_good_flag(good), .control_pin_on(ctl_on), .enable_pin_on(en_on), .operation_on(op_on),
    .other_fault_shutdown(other), .write_protect(write_protect), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults), .cmd_rdata(cmd_rdata),
    .host_alert_n(alert_n), .ov_fault_status_reg(ov_st), .uv_fault_status_reg(uv_st),
    .output_enable_reg(en));
  vfr_host_model host (.clk(clk), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .clear_faults(clear_faults), .write_protect(write_protect), .cmd_rdata(cmd_rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    step(2);
    @(posedge clk);
    reset_n <= 1'b1;
    step(3);
  endtask
  // Wait for the output to drop, then count edges until it returns; capped at R+8
  task automatic gap();
    n = 0;
    while (en !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    if (n == 20) begin
      failures++;
      tally_and_finish();
    end
    n = 0;
    while (en !== 1'b1 && n < R + 8) begin
      step(1);
      n++;
    end
  endtask
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] codes [5] = '{8'hBF, 8'hF8, 8'h7F, 8'h90, 8'h80};
    logic       retry [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    step(20);
    @(posedge clk);
    reset_n <= 1'b1;
    step(3);
    host.read_cmd(CMD_OV_ACTION, rd);
    check(rd, 16'h0080, "ov action default");
    host.read_cmd(CMD_UV_ACTION, rd);
    check(rd, 16'h0080, "uv action default");
    host.read_cmd(CMD_UV_THRESHOLD, rd);
    check(rd, 16'h1B33, "uv limit default");
    host.read_cmd(8'h46, rd);
    check(rd, 16'h0000, "unmapped read");
    host.protect(1'b1);
    host.write_cmd(CMD_UV_ACTION, 16'h00F8);
    host.read_cmd(CMD_UV_ACTION, rd);
    check(rd, 16'h0080, "protected write");
    host.protect(1'b0);
    host.write_cmd(CMD_UV_THRESHOLD, 16'hFFFF);
    host.read_cmd(CMD_UV_THRESHOLD, rd);
    check(rd, 16'hFFFF, "uv limit full width");
    host.write_cmd(CMD_UV_THRESHOLD, 16'h1B33);
    $display("Test registers done");
    @(posedge clk);
    vout <= LOW;
    step(5);
    check(16'(uv_st), 16'h0, "uv before power good");
    @(posedge clk);
    good <= 1'b1;
    ramp <= 1'b1;
    step(5);
    check(16'(uv_st), 16'h0, "uv during ramp");
    @(posedge clk);
    ramp <= 1'b0;
    step(2);
    check(16'({alert_n, uv_st, en}), 16'h2, "uv fault response");
    @(posedge clk);
    vout <= NORM;
    step(5);
    check(16'({alert_n, uv_st, en}), 16'h2, "uv latched");
    host.clear_all();
    step(2);
    check(16'({alert_n, uv_st, en}), 16'h5, "uv cleared");
    host.write_cmd(CMD_UV_ACTION, 16'h00B8);
    @(posedge clk);
    vout <= LOW;
    gap();
    check(16'(n), 16'(R + 1), "uv retry delay");
    @(posedge clk);
    en_on <= 1'b0;
    gap();
    check(16'(n), 16'(R + 8), "enable pin ends retry");
    @(posedge clk);
    vout <= NORM;
    en_on <= 1'b1;
    $display("Test undervoltage done");
    for (int i = 0; i < 5; i++) begin
      do_reset();
      host.write_cmd(CMD_OV_ACTION, {8'h00, codes[i]});
      @(posedge clk);
      vout <= HIGH;
      gap();
      check(16'(n), retry[i] ? 16'(R + 1) : 16'(R + 8), "ov retry code");
      check(16'({alert_n, ov_st}), 16'h1, "ov alert and status");
      @(posedge clk);
      vout <= NORM;
      host.clear_all();
      step(R + 4);
      check(16'({ov_st, en}), 16'(retry[i]), "ov after clear");
    end
    do_reset();
    host.write_cmd(CMD_OV_ACTION, 16'h00BF);
    @(posedge clk);
    vout <= HIGH;
    gap();
    gap();
    check(16'(n), 16'(R + 1), "ov repeated retry");
    @(posedge clk);
    ctl_on <= 1'b0;
    gap();
    check(16'(n), 16'(R + 8), "control pin ends retry");
    @(posedge clk);
    vout   <= NORM;
    ctl_on <= 1'b1;
    do_reset();
    host.write_cmd(CMD_OV_ACTION, 16'h00BF);
    @(posedge clk);
    vout <= HIGH;
    gap();
    @(posedge clk);
    op_on <= 1'b0;
    gap();
    check(16'(n), 16'(R + 8), "operation off ends retry");
    @(posedge clk);
    vout  <= NORM;
    op_on <= 1'b1;
    do_reset();
    host.write_cmd(CMD_OV_ACTION, 16'h00BF);
    @(posedge clk);
    vout <= HIGH;
    gap();
    @(posedge clk);
    other <= 1'b1;
    gap();
    check(16'(n), 16'(R + 8), "other fault ends retry");
    $display("Test overvoltage done");
    tally_and_finish();
  end
endmodule
